/* logic/isfl_cfg.svh */
`ifndef ISFL_CFG_SVH
`define ISFL_CFG_SVH
// ****************************************************************
// Register map (byte addresses on the APB bus)
// ****************************************************************
`define ISFL_OFS_STATUS   8'h00
`define ISFL_OFS_CTRL     8'h04
`define ISFL_OFS_IRQ_STAT 8'h08
`define ISFL_OFS_IRQ_CLR  8'h0c
`define ISFL_OFS_IRQ_EN   8'h10
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ISFL_CTRL_ENABLE   7
`define ISFL_CTRL_COMM_REL 6
`define ISFL_CTRL_WAIT_REL 5
`define ISFL_ST_XMIT       3
`define ISFL_ST_ACK        2
`define ISFL_ST_START      1
`define ISFL_ST_STOP       0
`define ISFL_IRQ_START     0
`define ISFL_IRQ_STOP      1
`define ISFL_IRQ_ACK       2
`define ISFL_CTRL_RESET    1'b0
`define ISFL_IRQ_RESET     3'h0
// ****************************************************************
// SCL rising-edge counts within a byte
// ****************************************************************
`define ISFL_CNT_IDLE 4'h0
`define ISFL_CNT_8TH  4'h7
`define ISFL_CNT_9TH  4'h8
`define ISFL_CNT_END  4'h9
`endif

/* logic/isfl_pkg.sv */
`default_nettype none
package isfl_pkg;
    typedef struct packed {
        logic xmit_dir;
        logic ack_seen;
        logic start_seen;
        logic stop_seen;
    } isfl_flags_t;
    typedef struct packed {
        logic ack;
        logic stop;
        logic start;
    } isfl_events_t;
endpackage
`default_nettype wire

/* logic/isfl_status_flags.sv */
// Summary of operation
// - Direction flag 0 means receive; SDA output stays released.
// - Direction flag 1 drives shift-out latch onto SDA; master at once, slave from 9th clock.
// - Master start generation sets the direction flag.
// - Slave sets direction flag when address byte LSB reads 1.
// - Master clears direction flag when it sends LSB 1 (read).
// - Stop, releases, enable fall, arbitration loss, idle clear direction.
// - SDA low at ninth SCL rise sets acknowledge flag.
// - Stop, next byte first clock, release, enable fall clear ack flag.
// - Start condition sets start flag; marks address period.
// - Stop, first clock after address byte, release, enable fall clear it.
// - Stop condition sets stop flag; bus is released.
// - First clock of next address byte or enable fall clears stop flag.
// - Control bit 7 is enable, bit 6 is release trigger.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "isfl_cfg.svh"
module isfl_status_flags (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Two-wire bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    // Neighbouring interface logic
    input  wire logic        master_in,
    input  wire logic        addr_match_in,
    input  wire logic        arb_lost_in,
    input  wire logic        start_gen_in,
    input  wire logic        so_latch_in,
    // Flags and interrupt
    output logic      [3:0]  flags_out,
    output logic             irq_out
);
    // ************************************************************
    // Pin synchronisers and bus condition detection
    // ************************************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    wire scl_s    = scl_sync[1];
    wire sda_s    = sda_sync[1];
    wire scl_rise = scl_s & ~scl_prev;
    // SDA moving while SCL stays high is a start or a stop
    wire scl_hi   = scl_s & scl_prev;
    wire start_det = scl_hi & sda_prev & ~sda_s;
    wire stop_det  = scl_hi & ~sda_prev & sda_s;

    // ************************************************************
    // Bit counter and address-byte tracking
    // ************************************************************
    logic [3:0] bit_cnt;
    logic       addr_byte;
    wire first_rise = scl_rise & ((bit_cnt == `ISFL_CNT_IDLE) |
                                  (bit_cnt == `ISFL_CNT_END));
    wire eighth     = scl_rise & (bit_cnt == `ISFL_CNT_8TH);
    wire ninth      = scl_rise & (bit_cnt == `ISFL_CNT_9TH);
    // First clock of the byte that follows the address byte
    wire after_addr = scl_rise & (bit_cnt == `ISFL_CNT_END) & addr_byte;
    // First clock of the address byte itself
    wire addr_first = scl_rise & (bit_cnt == `ISFL_CNT_IDLE) & addr_byte;
    wire [3:0] next_bit_cnt = (start_det | stop_det) ? `ISFL_CNT_IDLE :
                              first_rise ? 4'h1 :
                              scl_rise ? bit_cnt + 4'h1 : bit_cnt;
    wire next_addr_byte = start_det | (addr_byte & ~after_addr & ~stop_det);
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bit_cnt   <= `ISFL_CNT_IDLE;
            addr_byte <= 1'b0;
        end else begin
            bit_cnt   <= next_bit_cnt;
            addr_byte <= next_addr_byte;
        end
    end

    // ************************************************************
    // Control register and trigger pulses
    // ************************************************************
    logic       interface_enable;
    logic       enable_prev;
    logic       arb_prev;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    wire wr_go = psel_in & penable_in & pready_out & pwrite_in;
    wire sel_status = paddr_in == `ISFL_OFS_STATUS;
    wire sel_ctrl   = paddr_in == `ISFL_OFS_CTRL;
    wire sel_istat  = paddr_in == `ISFL_OFS_IRQ_STAT;
    wire sel_iclr   = paddr_in == `ISFL_OFS_IRQ_CLR;
    wire sel_ien    = paddr_in == `ISFL_OFS_IRQ_EN;
    wire mapped = sel_status | sel_ctrl | sel_istat | sel_iclr | sel_ien;
    wire wr_ctrl  = wr_go & sel_ctrl;
    // Release triggers are one-shot; they read back as zero
    wire comm_release_trigger =
        wr_ctrl & pwdata_in[`ISFL_CTRL_COMM_REL];
    wire wait_release_trigger = wr_ctrl & pwdata_in[`ISFL_CTRL_WAIT_REL];
    wire enable_fall = enable_prev & ~interface_enable;
    wire arb_rise    = arb_lost_in & ~arb_prev;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            interface_enable <= `ISFL_CTRL_RESET;
            enable_prev      <= `ISFL_CTRL_RESET;
            arb_prev         <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                interface_enable <= pwdata_in[`ISFL_CTRL_ENABLE];
            end
            enable_prev <= interface_enable;
            arb_prev    <= arb_lost_in;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    isfl_pkg::isfl_flags_t flags;
    isfl_pkg::isfl_flags_t next_flags;
    wire rel_any = comm_release_trigger | wait_release_trigger;
    wire lsb_one = eighth & addr_byte & sda_s;
    // Idle slave: no address match once the address period is over
    wire no_comm = ~master_in & ~addr_match_in & ~flags.start_seen;
    wire dir_set = start_gen_in |
                   (lsb_one & ~master_in);
    wire dir_clr = stop_det | rel_any | enable_fall |
                   arb_rise | (start_det & ~master_in) |
                   no_comm |
                   (lsb_one & master_in);
    wire ack_set = ninth & ~sda_s;
    wire ack_clr = stop_det | first_rise |
                   comm_release_trigger | enable_fall;
    wire start_clr = stop_det | after_addr |
                     comm_release_trigger | enable_fall;
    wire stop_clr  = addr_first | enable_fall;
    // A setting event wins over a clearing one in the same cycle
    assign next_flags.xmit_dir   = dir_set |
                                   (flags.xmit_dir & ~dir_clr);
    assign next_flags.ack_seen   = ack_set |
                                   (flags.ack_seen & ~ack_clr);
    assign next_flags.start_seen = start_det |
                                   (flags.start_seen & ~start_clr);
    assign next_flags.stop_seen  = stop_det |
                                   (flags.stop_seen & ~stop_clr);
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // ************************************************************
    // SDA drive
    // ************************************************************
    logic slave_window;
    // A slave transmitter only takes the line from the 9th clock on
    wire next_window = flags.xmit_dir & (slave_window | (ninth & addr_byte));
    wire drive_ok = flags.xmit_dir & (master_in | slave_window);
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            slave_window <= 1'b0;
            sda_oe_out   <= 1'b0;
            sda_out      <= 1'b0;
        end else begin
            slave_window <= next_window;
            // Open drain: only a low is ever driven
            sda_oe_out   <= drive_ok & ~so_latch_in;
            sda_out      <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupts and APB answer
    // ************************************************************
    isfl_pkg::isfl_events_t evt;
    assign evt.start = start_det;
    assign evt.stop  = stop_det;
    assign evt.ack   = ack_set;
    wire [2:0] clr_bits = (wr_go & sel_iclr) ? pwdata_in[2:0] : 3'h0;
    wire [2:0] next_irq_stat = evt | (irq_stat & ~clr_bits);
    wire [2:0] next_irq_en = (wr_go & sel_ien) ? pwdata_in[2:0] : irq_en;
    wire [7:0] status_word = {4'h0, flags};
    wire [31:0] rd_word =
        sel_status ? {24'h0, status_word} :
        sel_ctrl   ? {24'h0, interface_enable, 7'h00} :
        sel_istat  ? {29'h0, irq_stat} :
        sel_ien    ? {29'h0, irq_en} : 32'h0;
    wire setup = psel_in & ~penable_in;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_stat    <= `ISFL_IRQ_RESET;
            irq_en      <= `ISFL_IRQ_RESET;
            irq_out     <= 1'b0;
            flags_out   <= 4'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            irq_stat    <= next_irq_stat;
            irq_en      <= next_irq_en;
            irq_out     <= |(next_irq_stat & next_irq_en);
            flags_out   <= next_flags;
            pready_out  <= setup;
            pslverr_out <= setup & ~mapped;
            prdata_out  <= setup ? rd_word : 32'h0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    property p_rx_release;
        !flags.xmit_dir |=> !sda_oe_out;
    endproperty
    a_rx_release: assert property (p_rx_release)
        else $error("SDA driven while receiving");

    property p_tx_drive;
        drive_ok && !so_latch_in |=> sda_oe_out;
    endproperty
    a_tx_drive: assert property (p_tx_drive)
        else $error("SDA not driven while transmitting");

    property p_master_set;
        start_gen_in |=> flags.xmit_dir ##1
            (flags.xmit_dir || $past(dir_clr));
    endproperty
    a_master_set: assert property (p_master_set)
        else $error("direction flag not set on start generation");

    property p_slave_set;
        lsb_one && !master_in |=> flags.xmit_dir;
    endproperty
    a_slave_set: assert property (p_slave_set)
        else $error("slave direction flag not set");

    property p_master_read;
        lsb_one && master_in && !start_gen_in |=> !flags.xmit_dir;
    endproperty
    a_master_read: assert property (p_master_read)
        else $error("master read did not clear direction flag");

    property p_dir_stop;
        stop_det && !dir_set |=> !flags.xmit_dir;
    endproperty
    a_dir_stop: assert property (p_dir_stop)
        else $error("direction flag survived stop");

    property p_ack_seen;
        ninth && !sda_s |=> flags.ack_seen && flags_out[`ISFL_ST_ACK];
    endproperty
    a_ack_seen: assert property (p_ack_seen)
        else $error("acknowledge flag not set");

    property p_ack_clear;
        first_rise |=> !flags.ack_seen;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("acknowledge flag not cleared at byte start");

    property p_start_seen;
        start_det |=> flags.start_seen && addr_byte;
    endproperty
    a_start_seen: assert property (p_start_seen)
        else $error("start flag not set");

    property p_start_clear;
        after_addr && !start_det |=> !flags.start_seen;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start flag not cleared after address byte");

    property p_stop_seen;
        stop_det |=> flags.stop_seen && !flags.start_seen;
    endproperty
    a_stop_seen: assert property (p_stop_seen)
        else $error("stop flag not set");

    property p_stop_clear;
        addr_first && !stop_det |=> !flags.stop_seen;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("stop flag not cleared at address byte");

    property p_enable_off;
        wr_ctrl && interface_enable && !pwdata_in[`ISFL_CTRL_ENABLE]
            ##1 !start_det && !stop_det && !ack_set
            |=> !flags.start_seen && !flags.ack_seen && !flags.stop_seen;
    endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("flags not cleared when interface disabled");

endmodule // isfl_status_flags
`default_nettype wire

/* test/isfl_bus_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module isfl_bus_partner (
    // Clock
    input  wire logic clk_in,
    // Open-drain drive
    output logic      scl_out,
    output logic      sda_low_out
);
    // ****
    // Bus master model: data bits change mid SCL low; SDA moves while SCL high only for start and stop
    // ****
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic q(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic start_cond();
        sda_low_out <= 1'b1;
        q(10);
        scl_out <= 1'b0;
        q(5);
    endtask
    task automatic stop_cond();
        sda_low_out <= 1'b1;
        q(5);
        scl_out <= 1'b1;
        q(10);
        sda_low_out <= 1'b0;
        q(10);
    endtask
    // Eight bits then the ack slot; a 1 releases the line to the pull-up
    task automatic clock_byte(input logic [8:0] bits);
        for (int i = 8; i >= 0; i--) begin
            scl_out <= 1'b0;
            q(5);
            sda_low_out <= !bits[i];
            q(5);
            scl_out <= 1'b1;
            q(10);
        end
        scl_out <= 1'b0;
        q(5);
    endtask
endmodule // isfl_bus_partner
`default_nettype wire

/* test/i2c_status_flag_logic_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "isfl_cfg.svh"
module i2c_status_flag_logic_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl;
    logic        sda_low;
    logic        sda_out;
    logic        sda_oe;
    logic        sda_wire;
    logic        mst = 1'b0;
    logic        match = 1'b0;
    logic        arb = 1'b0;
    logic        sgen = 1'b0;
    logic        so_bit = 1'b1;
    logic [3:0]  flags;
    logic        irq;
    logic [31:0] q;
    logic        e;
    int          fail_count = 0;
    int          n_tests = 0;
    always #4 clk = ~clk;
    // Wired-AND with pull-up: low while either party pulls
    assign sda_wire = !(sda_low | (sda_oe & !sda_out));
    isfl_bus_partner p (.clk_in(clk), .scl_out(scl), .sda_low_out(sda_low));
    isfl_status_flags i_dut (
        .ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .master_in(mst),
        .addr_match_in(match), .arb_lost_in(arb), .start_gen_in(sgen),
        .so_latch_in(so_bit), .flags_out(flags), .irq_out(irq));
    // ****
    // Shared tasks
    // ****
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask
    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    task automatic fl(input logic [3:0] exp);
        repeat (6) @(posedge clk);
        chk("flags", {28'h0, exp}, {28'h0, flags});
    endtask
    task automatic start_gen();
        @(posedge clk);
        sgen <= 1'b1;
        @(posedge clk);
        sgen <= 1'b0;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        rd("status", `ISFL_OFS_STATUS, 32'h0);
        rd("ctrl", `ISFL_OFS_CTRL, 32'h0);
        rd("irq_en", `ISFL_OFS_IRQ_EN, 32'h0);
        apb(1'b1, `ISFL_OFS_STATUS, 32'hff);
        rd("status", `ISFL_OFS_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        $display("test regs done");
    endtask
    task automatic t_slave();
        apb(1'b1, `ISFL_OFS_CTRL, 32'h80);
        apb(1'b1, `ISFL_OFS_IRQ_EN, 32'h7);
        match <= 1'b1;
        so_bit <= 1'b0;
        p.start_cond();
        fl(4'b0010);
        chk("irq", 32'h1, {31'h0, irq});
        rd("irq_stat", `ISFL_OFS_IRQ_STAT, 32'h1);
        apb(1'b1, `ISFL_OFS_IRQ_CLR, 32'h7);
        rd("irq_stat", `ISFL_OFS_IRQ_STAT, 32'h0);
        p.clock_byte({8'ha1, 1'b0});
        fl(4'b1110);
        chk("sda_oe", 32'h1, {31'h0, sda_oe});
        so_bit <= 1'b1;
        p.clock_byte(9'h1ff);
        fl(4'b1000);
        chk("sda_oe", 32'h0, {31'h0, sda_oe});
        $display("test slave done");
    endtask
    task automatic t_stop();
        apb(1'b1, `ISFL_OFS_IRQ_CLR, 32'h7);
        apb(1'b1, `ISFL_OFS_IRQ_EN, 32'h0);
        p.stop_cond();
        fl(4'b0001);
        chk("sda_oe", 32'h0, {31'h0, sda_oe});
        rd("irq_stat", `ISFL_OFS_IRQ_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, `ISFL_OFS_IRQ_EN, 32'h2);
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `ISFL_OFS_IRQ_CLR, 32'h2);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        p.start_cond();
        fl(4'b0011);
        p.clock_byte({8'ha0, 1'b0});
        fl(4'b0110);
        $display("test stop done");
    endtask
    task automatic t_release();
        apb(1'b1, `ISFL_OFS_CTRL, 32'hc0);
        fl(4'b0000);
        rd("ctrl", `ISFL_OFS_CTRL, 32'h80);
        p.stop_cond();
        fl(4'b0001);
        $display("test release done");
    endtask
    task automatic t_master();
        match <= 1'b0;
        mst <= 1'b1;
        start_gen();
        fl(4'b1001);
        p.start_cond();
        p.clock_byte({8'ha1, 1'b1});
        fl(4'b0010);
        start_gen();
        fl(4'b1010);
        // SCL is low here, so pulling SDA makes no bus condition
        so_bit <= 1'b0;
        fl(4'b1010);
        chk("sda_oe", 32'h1, {31'h0, sda_oe});
        chk("sda_out", 32'h0, {31'h0, sda_out});
        so_bit <= 1'b1;
        arb <= 1'b1;
        fl(4'b0010);
        arb <= 1'b0;
        start_gen();
        fl(4'b1010);
        apb(1'b1, `ISFL_OFS_CTRL, 32'h0);
        fl(4'b0000);
        $display("test master done");
    endtask
    task automatic t_reset();
        start_gen();
        fl(4'b1000);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        fl(4'b0000);
        rd("ctrl", `ISFL_OFS_CTRL, 32'h0);
        $display("test reset done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_slave();
        t_stop();
        t_release();
        t_master();
        t_reset();
        wrap_up();
    end
endmodule // i2c_status_flag_logic_bench
`default_nettype wire
